// ==== logic/pdps_port_block.sv ====
`timescale 1ns/1ns
// What this block does
// - Every pin of every port has its own direction bit, independent of its neighbours.
// - A direction bit of 0 makes the pin an input and 1 makes it an output driven from its latch.
// - Reading a port returns the output latch for output pins instead of the sensed pin level.
// - An input pin has its driver turned off and is left floating by the port.
// - Writing to an input pin only updates its latch and the pin stays undriven.
// - With serial enabled, port two bits 4 to 7 carry receive, transmit, serial clock, ready.
// - Port two bit 7 also carries the timer X counter pin when that function is selected.
// - Port four bit 0 carries the timer Y counter pin when that function is selected.
// - Port four bits 1 to 4 feed external interrupts 0 to 3 and bit 4 may drive the PWM output.
module pdps_port_block
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Register port.
   input wire logic [pdps_pkg::ADDR_W-1:0] regAddr,
   input wire logic [pdps_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [pdps_pkg::DATA_W-1:0] regRdData,
   // Pins.
   input wire logic [pdps_pkg::DATA_W-1:0] portZeroIn,
   output logic [pdps_pkg::DATA_W-1:0] portZeroOut,
   output logic [pdps_pkg::DATA_W-1:0] portZeroOe,
   input wire logic [pdps_pkg::DATA_W-1:0] portOneIn,
   output logic [pdps_pkg::DATA_W-1:0] portOneOut,
   output logic [pdps_pkg::DATA_W-1:0] portOneOe,
   input wire logic [pdps_pkg::DATA_W-1:0] portTwoIn,
   output logic [pdps_pkg::DATA_W-1:0] portTwoOut,
   output logic [pdps_pkg::DATA_W-1:0] portTwoOe,
   input wire logic [pdps_pkg::DATA_W-1:0] portThreeIn,
   output logic [pdps_pkg::DATA_W-1:0] portThreeOut,
   output logic [pdps_pkg::DATA_W-1:0] portThreeOe,
   input wire logic [pdps_pkg::DATA_W-1:0] portFourIn,
   output logic [pdps_pkg::DATA_W-1:0] portFourOut,
   output logic [pdps_pkg::DATA_W-1:0] portFourOe,
   // Drive requests from the peripherals.
   input wire logic serialTxd,
   input wire logic serialClockOut,
   input wire logic serialClockOe,
   input wire logic serialReadyOut,
   input wire logic serialReadyOe,
   input wire logic timerXOut,
   input wire logic timerXOe,
   input wire logic timerYOut,
   input wire logic timerYOe,
   input wire logic pwmOut,
   input wire logic busDataFirstLow,
   input wire logic busClockFirstLow,
   input wire logic busDataSecondLow,
   input wire logic busClockSecondLow,
   input wire logic subclockDrive,
   // Pin levels and the analog input select handed to the peripherals.
   output logic serialRxd,
   output logic serialClockIn,
   output logic serialReadyIn,
   output logic timerXCounterPin,
   output logic timerYCounterPin,
   output logic [3:0] extInterrupt,
   output logic busDataFirst,
   output logic busClockFirst,
   output logic busDataSecond,
   output logic busClockSecond,
   output logic analogInputZeroSel,
   output logic subclockIn
);
   localparam int NP = pdps_pkg::NUM_PORTS;
   localparam int DW = pdps_pkg::DATA_W;

   logic [NP-1:0][DW-1:0] latch_r;
   logic [NP-1:0][DW-1:0] dir_r;
   logic [DW-1:0] funcSel_r;
   logic [NP-1:0][DW-1:0] pinOut_r;
   logic [NP-1:0][DW-1:0] pinOe_r;
   logic [DW-1:0] rdData_r;
   logic [14:0] periph_r;
   logic [NP-1:0][DW-1:0] pinIn;
   logic [NP-1:0][DW-1:0] ovEn;
   logic [NP-1:0][DW-1:0] ovOut;
   logic [NP-1:0][DW-1:0] ovOe;
   logic [NP-1:0][DW-1:0] pinOut_nxt;
   logic [NP-1:0][DW-1:0] pinOe_nxt;
   logic [NP-1:0][DW-1:0] readBack;
   logic [14:0] periph_nxt;
   logic [2:0] portIdx;
   logic isDir;
   logic portHit;
   logic funcHit;
   logic [DW-1:0] rdData_nxt;
   logic fsSer, fsTx, fsTy, fsPwm, fsB1, fsB2, fsAn, fsSub;

   assign pinIn = {portFourIn, portThreeIn, portTwoIn, portOneIn, portZeroIn};

   // Register decode.
   assign portIdx = regAddr[3:1];
   assign isDir = regAddr[0];
   assign portHit = regAddr <= pdps_pkg::PORT_LAST_DIR;
   assign funcHit = regAddr == pdps_pkg::FUNC_SEL;

   assign fsSer = funcSel_r[pdps_pkg::FS_SERIAL];
   assign fsTx = funcSel_r[pdps_pkg::FS_TIMER_X];
   assign fsTy = funcSel_r[pdps_pkg::FS_TIMER_Y];
   assign fsPwm = funcSel_r[pdps_pkg::FS_PWM];
   assign fsB1 = funcSel_r[pdps_pkg::FS_BUS_FIRST];
   assign fsB2 = funcSel_r[pdps_pkg::FS_BUS_SECOND];
   assign fsAn = funcSel_r[pdps_pkg::FS_ANALOG];
   assign fsSub = funcSel_r[pdps_pkg::FS_SUBCLOCK];

   // Peripheral overrides; the second bus takes bits 4/5 ahead of the serial unit.
   assign ovEn[0] = 8'h00;
   assign ovOut[0] = 8'h00;
   assign ovOe[0] = 8'h00;
   assign ovEn[1] = 8'h00;
   assign ovOut[1] = 8'h00;
   assign ovOe[1] = 8'h00;
   assign ovEn[2] = {fsTx | fsSer, fsSer, fsB2 | fsSer, fsB2 | fsSer,
                     fsB1, fsB1, fsSub, fsSub};
   assign ovOut[2] = {fsTx ? timerXOut : serialReadyOut, serialClockOut,
                      ~fsB2 & serialTxd, 1'h0, 1'h0, 1'h0, 1'h0, subclockDrive};
   assign ovOe[2] = {fsTx ? timerXOe : serialReadyOe, serialClockOe,
                     fsB2 ? busClockSecondLow : 1'h1, fsB2 & busDataSecondLow,
                     busClockFirstLow, busDataFirstLow, 1'h0, 1'h1};
   assign ovEn[3] = {7'h00, fsAn};
   assign ovOut[3] = 8'h00;
   assign ovOe[3] = 8'h00;
   assign ovEn[4] = {3'h0, fsPwm, 3'h0, fsTy};
   assign ovOut[4] = {3'h0, pwmOut, 3'h0, timerYOut};
   assign ovOe[4] = {3'h0, 1'h1, 3'h0, timerYOe};

   // Plain port pins follow latch and direction; a direction bit of 0 floats the pin.
   assign pinOut_nxt = (ovEn & ovOut) | (~ovEn & latch_r);
   assign pinOe_nxt = (ovEn & ovOe) | (~ovEn & dir_r);
   assign readBack = (dir_r & latch_r) | (~dir_r & pinIn);

   assign rdData_nxt = !regRead ? rdData_r :
                       portHit ? (isDir ? dir_r[portIdx] : readBack[portIdx]) :
                       funcHit ? funcSel_r : pdps_pkg::UNMAPPED_READ;

   // Peripherals see the raw pin levels; edge choice lives in the interrupt logic.
   assign periph_nxt = {pinIn[2][4], pinIn[2][6], pinIn[2][7], pinIn[2][7], pinIn[4][0],
                        pinIn[4][4:1], pinIn[2][2], pinIn[2][3], pinIn[2][4], pinIn[2][5],
                        fsAn, pinIn[2][1]};

   // One latch and one direction bit per pin, written independently.
   genvar p;
   generate
      for (p = 0; p < NP; p++)
      begin : g_port
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               latch_r[p] <= pdps_pkg::LATCH_RESET;
               dir_r[p] <= pdps_pkg::DIR_RESET;
            end
            else if (regWrite && portHit && portIdx == 3'(p))
            begin
               if (isDir)
                  dir_r[p] <= regWrData;
               else
                  latch_r[p] <= regWrData;
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         funcSel_r <= pdps_pkg::FUNC_RESET;
      else if (regWrite && funcHit)
         funcSel_r <= regWrData;
   end

   // Pins and peripheral levels are registered so every output comes from a flip-flop.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinOut_r <= '0;
         pinOe_r <= '0;
         periph_r <= '0;
         rdData_r <= pdps_pkg::UNMAPPED_READ;
      end
      else
      begin
         pinOut_r <= pinOut_nxt;
         pinOe_r <= pinOe_nxt;
         periph_r <= periph_nxt;
         rdData_r <= rdData_nxt;
      end
   end

   assign regRdData = rdData_r;
   assign {portFourOut, portThreeOut, portTwoOut, portOneOut, portZeroOut} = pinOut_r;
   assign {portFourOe, portThreeOe, portTwoOe, portOneOe, portZeroOe} = pinOe_r;
   assign {serialRxd, serialClockIn, serialReadyIn, timerXCounterPin, timerYCounterPin,
           extInterrupt, busDataFirst, busClockFirst, busDataSecond, busClockSecond,
           analogInputZeroSel, subclockIn} = periph_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_dir_write_one: assert property (regWrite && portHit && isDir |=>
      dir_r[$past(portIdx)] == $past(regWrData)) else $error("direction write lost");
   a_port0_follows: assert property (##1 portZeroOe == $past(dir_r[0])
      && (portZeroOut & portZeroOe) == $past(latch_r[0] & dir_r[0]))
      else $error("port zero drive wrong");
   a_read_latch: assert property (regRead && portHit && !isDir |=>
      regRdData == $past(readBack[portIdx])) else $error("port read wrong");
   a_input_float: assert property (##1 ((portOneOe | portZeroOe)
      & ~$past(dir_r[1] | dir_r[0])) == 8'h00) else $error("input pin driven");
   a_write_input_pin: assert property (regWrite && portHit && !isDir
      && portIdx == 3'h1 && dir_r[1] == 8'h00 |=> ##1 portOneOe == 8'h00)
      else $error("input pin driven after write");
   a_serial_txd: assert property (fsSer && !fsB2 |=>
      portTwoOut[5] == $past(serialTxd) && portTwoOe[5])
      else $error("serial transmit not routed");
   a_timer_x_pin: assert property (fsTx |=> portTwoOut[7] == $past(timerXOut)
      && portTwoOe[7] == $past(timerXOe)) else $error("timer X pin not routed");
   a_timer_y_pin: assert property (fsTy |=> portFourOut[0] == $past(timerYOut))
      else $error("timer Y pin not routed");
   // The level flops are still in reset on the release edge, so the check starts one edge later.
   a_ext_irq_pwm: assert property ($past(rst_n) |->
      extInterrupt == $past(portFourIn[4:1])
      && (!$past(fsPwm) || portFourOut[4] == $past(pwmOut)))
      else $error("interrupt or PWM path wrong");
   a_bus_open_drain: assert property (fsB1 |=> portTwoOut[3:2] == 2'h0
      && portTwoOe[2] == $past(busDataFirstLow)) else $error("bus pin not open-drain");
   a_analog_float: assert property (fsAn |=> !portThreeOe[0] && analogInputZeroSel)
      else $error("analog pin driven");

   c_output_read: cover property (regRead && portHit && !isDir && dir_r[portIdx] != 8'h00);
   c_serial_mode: cover property (fsSer && serialClockOe);
   c_bus_low: cover property (fsB1 && busDataFirstLow ##1 portTwoOe[2]);
   c_pwm_drive: cover property (fsPwm && pwmOut);
endmodule // pdps_port_block

// ==== logic/pdps_pkg.sv ====
package pdps_pkg;
   // Register bus geometry.
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int NUM_PORTS = 5;

   // Each port has a data register at an even offset and its direction register just above.
   localparam logic [ADDR_W-1:0] PORT_ZERO_DATA = 6'h00;
   localparam logic [ADDR_W-1:0] PORT_ZERO_DIR = 6'h01;
   localparam logic [ADDR_W-1:0] PORT_ONE_DATA = 6'h02;
   localparam logic [ADDR_W-1:0] PORT_ONE_DIR = 6'h03;
   localparam logic [ADDR_W-1:0] PORT_TWO_DATA = 6'h04;
   localparam logic [ADDR_W-1:0] PORT_TWO_DIR = 6'h05;
   localparam logic [ADDR_W-1:0] PORT_THREE_DATA = 6'h06;
   localparam logic [ADDR_W-1:0] PORT_THREE_DIR = 6'h07;
   localparam logic [ADDR_W-1:0] PORT_FOUR_DATA = 6'h08;
   localparam logic [ADDR_W-1:0] PORT_FOUR_DIR = 6'h09;
   localparam logic [ADDR_W-1:0] FUNC_SEL = 6'h0A;
   localparam logic [ADDR_W-1:0] PORT_LAST_DIR = PORT_FOUR_DIR;

   // Field positions in the function select register.
   localparam int FS_SERIAL = 0;
   localparam int FS_TIMER_X = 1;
   localparam int FS_TIMER_Y = 2;
   localparam int FS_PWM = 3;
   localparam int FS_BUS_FIRST = 4;
   localparam int FS_BUS_SECOND = 5;
   localparam int FS_ANALOG = 6;
   localparam int FS_SUBCLOCK = 7;

   // Reset values: all pins inputs, latches clear, every pin a plain port pin.
   localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DIR_RESET = 8'h00;
   localparam logic [DATA_W-1:0] FUNC_RESET = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
endpackage

// ==== tb/pdps_pin_model.sv ====
`timescale 1ns/1ns
module pdps_pin_model
(
   // Clock.
   input wire logic clock,
   // Drive from the port block.
   input wire logic [39:0] devOut,
   input wire logic [39:0] devOe,
   // Drive from the outside circuit.
   input wire logic [39:0] extOut,
   input wire logic [39:0] extOe,
   // Resolved pin levels.
   output logic [39:0] pins
);
   logic [39:0] drift_r;
   initial drift_r = 40'h5555555555;
   // A pin that nobody drives toggles, so a floating pin never reads back right by luck.
   always @(posedge clock) drift_r <= ~drift_r;
   assign pins = (devOe & devOut) | (~devOe & extOe & extOut) | (~devOe & ~extOe & drift_r);
endmodule // pdps_pin_model

// ==== tb/tb_pdps_port_block.sv ====
`timescale 1ns/1ns
module tb_pdps_port_block;
   logic clock, rst_n, regWrite, regRead;
   logic [5:0] regAddr;
   logic [7:0] regWrData, regRdData;
   logic [14:0] per;
   logic [39:0] extOut, extOe;
   wire logic [39:0] allOut, allOe, pins;
   wire logic [14:0] obs;
   int fails, checkCount, cycles;
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   pdps_port_block u_dut
   (
      .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .portZeroIn(pins[7:0]), .portZeroOut(allOut[7:0]), .portZeroOe(allOe[7:0]),
      .portOneIn(pins[15:8]), .portOneOut(allOut[15:8]), .portOneOe(allOe[15:8]),
      .portTwoIn(pins[23:16]), .portTwoOut(allOut[23:16]), .portTwoOe(allOe[23:16]),
      .portThreeIn(pins[31:24]), .portThreeOut(allOut[31:24]), .portThreeOe(allOe[31:24]),
      .portFourIn(pins[39:32]), .portFourOut(allOut[39:32]), .portFourOe(allOe[39:32]),
      .serialTxd(per[0]), .serialClockOut(per[1]), .serialClockOe(per[2]),
      .serialReadyOut(per[3]), .serialReadyOe(per[4]), .timerXOut(per[5]), .timerXOe(per[6]),
      .timerYOut(per[7]), .timerYOe(per[8]), .pwmOut(per[9]), .busDataFirstLow(per[10]),
      .busClockFirstLow(per[11]), .busDataSecondLow(per[12]), .busClockSecondLow(per[13]),
      .subclockDrive(per[14]), .serialRxd(obs[0]), .serialClockIn(obs[1]),
      .serialReadyIn(obs[2]), .timerXCounterPin(obs[3]), .timerYCounterPin(obs[4]),
      .extInterrupt(obs[8:5]), .busDataFirst(obs[9]), .busClockFirst(obs[10]),
      .busDataSecond(obs[11]), .busClockSecond(obs[12]), .subclockIn(obs[13]),
      .analogInputZeroSel(obs[14])
   );
   pdps_pin_model u_pins
   (
      .clock(clock), .devOut(allOut), .devOe(allOe), .extOut(extOut), .extOe(extOe),
      .pins(pins)
   );
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checkCount++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rdChk(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   // Pins lag a register write by one edge and peripheral levels by two, so every pin check waits two edges.
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic testReset();
      for (int p = 0; p < 5; p++)
         chk(allOe[8*p +: 8], 8'h00);
      rdChk(pdps_pkg::FUNC_SEL, 8'h00);
      rdChk(6'h3F, 8'h00);
      $display("reset test done");
   endtask
   task automatic testPlain();
      logic [5:0] a;
      @(posedge clock);
      extOut <= {5{8'hC3}};
      extOe <= {5{8'h5A}};
      for (int p = 0; p < 5; p++)
      begin
         a = 6'(2 * p);
         wr(a, 8'h3C);
         wr(a + 6'h01, 8'hA5);
         settle();
         chk(allOe[8*p +: 8], 8'hA5);
         chk(allOut[8*p +: 8] & 8'hA5, 8'h24);
         rdChk(a, 8'h66);
         rdChk(a + 6'h01, 8'hA5);
         wr(a, 8'hFF);
         settle();
         chk(allOe[8*p +: 8], 8'hA5);
         chk(allOut[8*p +: 8] & 8'hA5, 8'hA5);
         wr(a + 6'h01, 8'h00);
      end
      $display("plain port test done");
   endtask
   task automatic testSerial();
      @(posedge clock);
      extOut[23:16] <= 8'h90;
      extOe[23:16] <= 8'h90;
      per <= 15'h0017;
      wr(pdps_pkg::FUNC_SEL, 8'h01);
      settle();
      chk(allOe[23:16] & 8'hF0, 8'hE0);
      chk(allOut[23:16] & 8'hE0, 8'h60);
      chk({5'h00, obs[2:0]}, 8'h03);
      $display("serial test done");
   endtask
   task automatic testShared();
      @(posedge clock);
      extOut[39:32] <= 8'h0A;
      extOe[39:32] <= 8'h0E;
      per <= 15'h03D8;
      wr(pdps_pkg::FUNC_SEL, 8'h0F);
      settle();
      chk({2'b00, allOe[23], allOut[23], allOe[32], allOut[32], allOe[36], allOut[36]},
         8'h2F);
      chk({2'b00, obs[8:3]}, 8'h36);
      rdChk(pdps_pkg::FUNC_SEL, 8'h0F);
      $display("timer and interrupt test done");
   endtask
   task automatic testBus();
      @(posedge clock);
      extOut[23:16] <= 8'h18;
      extOe[23:16] <= 8'h18;
      // Serial stays on with its transmit high, so bit 5 shows that the second bus wins.
      per <= 15'h2401;
      wr(pdps_pkg::FUNC_SEL, 8'h31);
      settle();
      chk(allOe[23:16] & 8'h3C, 8'h24);
      chk(allOut[23:16] & 8'h3C, 8'h00);
      chk({4'h0, obs[12:9]}, 8'h06);
      $display("two-wire bus test done");
   endtask
   task automatic testAnalogSub();
      @(posedge clock);
      extOut[23:16] <= 8'h00;
      extOe[23:16] <= 8'h02;
      per <= 15'h4000;
      wr(pdps_pkg::PORT_THREE_DIR, 8'hFF);
      wr(pdps_pkg::PORT_TWO_DIR, 8'hFF);
      wr(pdps_pkg::FUNC_SEL, 8'hC0);
      settle();
      chk(allOe[31:24], 8'hFE);
      chk({5'h00, allOe[17:16], allOut[16]}, 8'h03);
      chk({6'h00, obs[14:13]}, 8'h02);
      $display("analog and sub-clock test done");
   endtask
   task automatic stopTest();
      $display("checks %0d, mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         stopTest();
      end
   end
   initial
   begin
      rst_n = 1'b0;
      regAddr = 6'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      per = 15'h0000;
      extOut = 40'h0000000000;
      extOe = 40'h0000000000;
      fails = 0;
      checkCount = 0;
      cycles = 0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      testReset();
      testPlain();
      testSerial();
      testShared();
      testBus();
      testAnalogSub();
      stopTest();
   end
endmodule // tb_pdps_port_block
